// ==== design/flyback_consts.svh ====
`ifndef FLYBACK_CONSTS_SVH
`define FLYBACK_CONSTS_SVH
// Clock rate in kHz (125 MHz)
`define CLK_KHZ 125000
// Switching frequencies in kHz
`define F_LOW_NORM_KHZ 65
`define F_LOW_BOOST_KHZ 130
`define F_HIGH_NORM_KHZ 100
`define F_HIGH_BOOST_KHZ 200
`define F_MIN_KHZ 25
// Foldback runs at twice the minimum frequency
`define F_FOLD_DIV 2
// Dither span in percent, period in us
`define DITHER_PCT 5
`define DITHER_PERIOD_US 4400
`define DITHER_STEPS 20
// Timers in us
`define OPP_TIME_US 85000
`define BROWNOUT_TIME_US 44000
// Cycle counts
`define VDD_OV_CYCLES 3
`define FLT_OV_CYCLES 3
`define FLT_OT_CYCLES 32
`define SHORT_CYCLES 8
`define DIE_OT_CYCLES 32
// Duty limit in percent
`define DUTY_MAX_PCT 80
// Leading-edge blanking in ns
`define LEB_NS 250
`define CLK_NS 8
`endif

// ==== design/flyback_pkg.sv ====
package flyback_pkg;
   typedef enum logic [2:0] {
      BAND_STOP = 3'b000,
      BAND_BURST = 3'b001,
      BAND_MINF = 3'b010,
      BAND_FOLD = 3'b011,
      BAND_NORM = 3'b100,
      BAND_BOOST = 3'b101
   } band_e;

   typedef struct packed {
      logic boost;
      logic normal;
      logic foldback;
      logic minfreq;
      logic burst;
   } fb_flags_s;

   typedef struct packed {
      logic vdd_ov;
      logic opp;
      logic brownout;
      logic flt_ov;
      logic flt_ot;
      logic short_circ;
      logic die_ot;
      logic disabled;
   } fault_s;
endpackage

// ==== design/cycle_qualifier.sv ====
`timescale 1ns/100ps
`include "flyback_consts.svh"
module cycle_qualifier #(
   parameter logic [5:0] LIMIT = 6'h03
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Switching cycle strobe and condition
   input wire logic cycle_end,
   input wire logic cond,
   // Qualified fault level
   output logic tripped
);
   logic [5:0] cnt_q, cnt_d;
   logic trip_q, trip_d;

   always_comb begin
      cnt_d = cnt_q;
      trip_d = trip_q;
      if (cycle_end) begin
         if (!cond) begin
            cnt_d = 6'h00;
         end else if (cnt_q < LIMIT) begin
            cnt_d = cnt_q + 6'h01;
         end
         trip_d = cond && (cnt_q + 6'h01 >= LIMIT);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= 6'h00;
         trip_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         trip_q <= trip_d;
      end
   end

   assign tripped = trip_q;
endmodule

// ==== design/flyback_timing.sv ====
`timescale 1ns/100ps
`include "flyback_consts.svh"
// Function
// - Low variant: 65 kHz normal band, up to 130 kHz in boost.
// - High variant: 100 kHz normal band, up to 200 kHz in boost.
// - Dither switching frequency by plus or minus five percent.
// - Dither triangle repeats every 4.4 ms peak to peak.
// - Supply over-voltage stops switching after 3 consecutive cycles.
// - Over-power fault after feedback at threshold continuously 85 ms.
// - Brownout stops switching after comparator active 44 ms continuously.
// - Fault pin over-voltage stops switching after 3 cycles.
// - Fault pin over-temperature stops switching after 32 cycles.
// - Short-circuit fault after 8 cycles over limit during blanking.
// - Die over-temperature shutdown after 32 cycles of flag.
// - Leave external disable at once when pin rises above threshold.
// - Resume immediately after brownout once pin recovers.
// - Short pulse means sense over 900 mV within blanking window.
module flyback_timing (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Variant strap: 1 selects the 100 kHz variant
   input wire logic high_variant,
   // Analogue comparators
   input wire flyback_pkg::fb_flags_s feedback_level,
   input wire logic opp_cmp,
   input wire logic vdd_ov_cmp,
   input wire logic cs_limit_cmp,
   input wire logic die_hot_cmp,
   // Fault pin comparators
   input wire logic fault_sense_pin_dis,
   input wire logic fault_sense_pin_brown,
   input wire logic fault_sense_pin_ov,
   input wire logic fault_sense_pin_ot,
   // Gate and status
   output logic gate_drive_out,
   output flyback_pkg::band_e band,
   output flyback_pkg::fault_s faults
);
   localparam int DIV_LOW_NORM = `CLK_KHZ / `F_LOW_NORM_KHZ;
   localparam int DIV_LOW_BOOST = `CLK_KHZ / `F_LOW_BOOST_KHZ;
   localparam int DIV_HIGH_NORM = `CLK_KHZ / `F_HIGH_NORM_KHZ;
   localparam int DIV_HIGH_BOOST = `CLK_KHZ / `F_HIGH_BOOST_KHZ;
   localparam int DIV_MIN = `CLK_KHZ / `F_MIN_KHZ;
   localparam int US_CYC = `CLK_KHZ / 1000;
   localparam int OPP_CYC = `OPP_TIME_US * US_CYC;
   localparam int BO_CYC = `BROWNOUT_TIME_US * US_CYC;
   localparam int DITH_STEP_CYC = `DITHER_PERIOD_US * US_CYC / (2 * `DITHER_STEPS);
   localparam int LEB_CYC = (`LEB_NS + `CLK_NS - 1) / `CLK_NS;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [13:0] raw_in, meta_q, sync_q;
   assign raw_in = {high_variant, feedback_level, opp_cmp, vdd_ov_cmp, cs_limit_cmp,
                    die_hot_cmp, fault_sense_pin_dis, fault_sense_pin_brown,
                    fault_sense_pin_ov, fault_sense_pin_ot};
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= 14'h0000;
         sync_q <= 14'h0000;
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
      end
   end
   logic s_high, s_opp, s_vdd_ov, s_cs, s_die, s_dis, s_brown, s_ov, s_ot;
   flyback_pkg::fb_flags_s s_fb;
   assign {s_high, s_fb, s_opp, s_vdd_ov, s_cs, s_die, s_dis, s_brown, s_ov, s_ot} = sync_q;

   // ----------------------------------------
   // Band selection
   // ----------------------------------------
   function automatic flyback_pkg::band_e pick_band(input flyback_pkg::fb_flags_s f);
      if (f.boost) pick_band = flyback_pkg::BAND_BOOST;
      else if (f.normal) pick_band = flyback_pkg::BAND_NORM;
      else if (f.foldback) pick_band = flyback_pkg::BAND_FOLD;
      else if (f.minfreq) pick_band = flyback_pkg::BAND_MINF;
      else if (f.burst) pick_band = flyback_pkg::BAND_BURST;
      else pick_band = flyback_pkg::BAND_STOP;
   endfunction

   // ----------------------------------------
   // Dither triangle
   // ----------------------------------------
   logic [19:0] dstep_q, dstep_d;
   logic [4:0] dpos_q, dpos_d;
   logic dup_q, dup_d;
   always_comb begin
      dstep_d = dstep_q + 20'h00001;
      dpos_d = dpos_q;
      dup_d = dup_q;
      if (dstep_q >= 20'(DITH_STEP_CYC - 1)) begin
         dstep_d = 20'h00000;
         if (dup_q) begin
            if (dpos_q >= 5'(`DITHER_STEPS - 1)) dup_d = 1'b0;
            dpos_d = dpos_q + 5'h01;
         end else begin
            if (dpos_q <= 5'h01) dup_d = 1'b1;
            dpos_d = dpos_q - 5'h01;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dstep_q <= 20'h00000;
         dpos_q <= 5'h00;
         dup_q <= 1'b1;
      end else begin
         dstep_q <= dstep_d;
         dpos_q <= dpos_d;
         dup_q <= dup_d;
      end
   end

   // ----------------------------------------
   // Period selection
   // ----------------------------------------
   logic [15:0] base_per, period;
   logic [31:0] swing;
   always_comb begin
      case (pick_band(s_fb))
         flyback_pkg::BAND_BOOST:
            base_per = s_high ? 16'(DIV_HIGH_BOOST) : 16'(DIV_LOW_BOOST);
         flyback_pkg::BAND_NORM:
            base_per = s_high ? 16'(DIV_HIGH_NORM) : 16'(DIV_LOW_NORM);
         flyback_pkg::BAND_FOLD:
            base_per = 16'(DIV_MIN / `F_FOLD_DIV);
         default:
            base_per = 16'(DIV_MIN);
      endcase
      swing = 32'(base_per) * `DITHER_PCT * 32'(dpos_q) / (50 * `DITHER_STEPS);
      period = base_per - 16'(32'(base_per) * `DITHER_PCT / 100) + 16'(swing);
   end

   // ----------------------------------------
   // Switching cycle
   // ----------------------------------------
   logic [15:0] pcnt_q, pcnt_d;
   logic [15:0] plen_q, plen_d;
   logic cyc_end, stop, short_seen_q, short_seen_d, gate_q, gate_d;
   always_comb begin
      pcnt_d = pcnt_q + 16'h0001;
      plen_d = plen_q;
      cyc_end = 1'b0;
      if (pcnt_q >= plen_q - 16'h0001) begin
         pcnt_d = 16'h0000;
         plen_d = period;
         cyc_end = 1'b1;
      end
      // Burst band switches only when not stopped; no pulse in stop band
      gate_d = !stop && pick_band(s_fb) != flyback_pkg::BAND_STOP &&
               (32'(pcnt_d) * 100 < 32'(plen_d) * `DUTY_MAX_PCT);
      short_seen_d = short_seen_q;
      if (cyc_end) short_seen_d = 1'b0;
      else if (gate_q && pcnt_q < 16'(LEB_CYC) && s_cs) short_seen_d = 1'b1;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pcnt_q <= 16'h0000;
         plen_q <= 16'(DIV_LOW_NORM);
         gate_q <= 1'b0;
         short_seen_q <= 1'b0;
      end else begin
         pcnt_q <= pcnt_d;
         plen_q <= plen_d;
         gate_q <= gate_d;
         short_seen_q <= short_seen_d;
      end
   end

   // ----------------------------------------
   // Cycle-count qualifiers
   // ----------------------------------------
   logic [4:0] q_cond, q_trip;
   localparam logic [5:0] QLIM [5] = '{6'(`VDD_OV_CYCLES), 6'(`FLT_OV_CYCLES),
      6'(`FLT_OT_CYCLES), 6'(`SHORT_CYCLES), 6'(`DIE_OT_CYCLES)};
   assign q_cond = {s_vdd_ov, s_ov, s_ot, short_seen_q, s_die};
   for (genvar i = 0; i < 5; i++) begin : g_qual
      cycle_qualifier #(.LIMIT(QLIM[4 - i])) u_qual (
         .clk(clk),
         .sys_rst(sys_rst),
         .cycle_end(cyc_end),
         .cond(q_cond[i]),
         .tripped(q_trip[i])
      );
   end

   // ----------------------------------------
   // Millisecond timers
   // ----------------------------------------
   logic [23:0] opp_q, opp_d, bo_q, bo_d;
   logic opp_f_q, opp_f_d, bo_f_q, bo_f_d;
   always_comb begin
      opp_d = s_opp ? ((opp_q < 24'(OPP_CYC)) ? opp_q + 24'h000001 : opp_q) : 24'h000000;
      opp_f_d = s_opp && opp_q >= 24'(OPP_CYC - 1);
      bo_d = s_brown ? ((bo_q < 24'(BO_CYC)) ? bo_q + 24'h000001 : bo_q) : 24'h000000;
      // clears as soon as pin recovers
      bo_f_d = s_brown && bo_q >= 24'(BO_CYC - 1);
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         opp_q <= 24'h000000;
         bo_q <= 24'h000000;
         opp_f_q <= 1'b0;
         bo_f_q <= 1'b0;
      end else begin
         opp_q <= opp_d;
         bo_q <= bo_d;
         opp_f_q <= opp_f_d;
         bo_f_q <= bo_f_d;
      end
   end

   // ----------------------------------------
   // Fault gathering and outputs
   // ----------------------------------------
   flyback_pkg::fault_s flt_d, flt_q;
   flyback_pkg::band_e band_q;
   always_comb begin
      flt_d.vdd_ov = q_trip[4];
      flt_d.opp = opp_f_q;
      flt_d.brownout = bo_f_q;
      flt_d.flt_ov = q_trip[3];
      flt_d.flt_ot = q_trip[2];
      flt_d.short_circ = q_trip[1];
      flt_d.die_ot = q_trip[0];
      flt_d.disabled = s_dis;
   end
   // Faults release when cause clears; no latch-off, a trade for simplicity
   assign stop = |flt_d;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flt_q <= '0;
         band_q <= flyback_pkg::BAND_STOP;
      end else begin
         flt_q <= flt_d;
         band_q <= pick_band(s_fb);
      end
   end
   assign gate_drive_out = gate_q;
   assign band = band_q;
   assign faults = flt_q;
endmodule

// ==== testbench/flyback_timing_assertions.sv ====
`timescale 1ns/100ps
module flyback_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Comparator inputs
   input wire flyback_pkg::fb_flags_s feedback_level,
   input wire logic opp_cmp,
   input wire logic vdd_ov_cmp,
   input wire logic fault_sense_pin_dis,
   input wire logic fault_sense_pin_brown,
   // Outputs
   input wire logic gate_drive_out,
   input wire flyback_pkg::band_e band,
   input wire flyback_pkg::fault_s faults
);
   // ---------
   // Properties
   // ---------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_BAND_BOOST: assert property (
      feedback_level.boost [*4] |-> band == flyback_pkg::BAND_BOOST)
      else $error("band not boost");
   AST_BAND_NORM: assert property (
      (feedback_level.normal && !feedback_level.boost) [*4] |-> band == flyback_pkg::BAND_NORM)
      else $error("band not normal");
   AST_BAND_STOP: assert property (
      (feedback_level == 5'h00) [*4] |-> band == flyback_pkg::BAND_STOP)
      else $error("band not stop");
   AST_GATE_OFF: assert property (
      (|faults) [*3] |-> !gate_drive_out)
      else $error("gate on during fault");
   AST_VDD_CAUSE: assert property (
      $rose(faults.vdd_ov) |-> $past(vdd_ov_cmp, 6) && vdd_ov_cmp)
      else $error("supply fault without cause");
   AST_DIS_ON: assert property (
      fault_sense_pin_dis [*4] |-> faults.disabled)
      else $error("disable missed");
   AST_DIS_OFF: assert property (
      !fault_sense_pin_dis [*4] |-> !faults.disabled)
      else $error("disable held");
   // Timer flag adds one register stage over the disable path
   AST_BROWN_OFF: assert property (
      !fault_sense_pin_brown [*5] |-> !faults.brownout)
      else $error("brownout held");
   AST_OPP_OFF: assert property (
      !opp_cmp [*5] |-> !faults.opp)
      else $error("power fault held");
endmodule
bind flyback_timing flyback_checker chk_u (.clk(clk), .sys_rst(sys_rst),
   .feedback_level(feedback_level), .opp_cmp(opp_cmp), .vdd_ov_cmp(vdd_ov_cmp),
   .fault_sense_pin_dis(fault_sense_pin_dis), .fault_sense_pin_brown(fault_sense_pin_brown),
   .gate_drive_out(gate_drive_out), .band(band), .faults(faults));

// ==== testbench/sense_model.sv ====
`timescale 1ns/100ps
module sense_model (
   // Clock
   input wire logic clk,
   // Gate and scenario control
   input wire logic gate_drive_out,
   input wire logic short_mode,
   // Comparator
   output logic cs_limit_cmp
);
   initial cs_limit_cmp = 1'b0;
   always @(negedge clk) begin
      cs_limit_cmp <= short_mode && gate_drive_out;
   end
endmodule

// ==== testbench/tb_flyback_switch_timing_faults.sv ====
`timescale 1ns/100ps
`include "flyback_consts.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_flyback_switch_timing_faults;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hv = 1'b1;
   flyback_pkg::fb_flags_s fb = '0;
   logic opp = 1'b0, vdd = 1'b0, die = 1'b0, dis = 1'b0, brown = 1'b0;
   logic fov = 1'b0, fot = 1'b0, shrt = 1'b0, cs, gate;
   flyback_pkg::band_e band;
   flyback_pkg::fault_s faults;
   int fails = 0, checks = 0, cyc = 0, t;
   flyback_timing dut_u (.clk(clk), .sys_rst(sys_rst), .high_variant(hv),
      .feedback_level(fb), .opp_cmp(opp), .vdd_ov_cmp(vdd), .cs_limit_cmp(cs),
      .die_hot_cmp(die), .fault_sense_pin_dis(dis), .fault_sense_pin_brown(brown),
      .fault_sense_pin_ov(fov), .fault_sense_pin_ot(fot), .gate_drive_out(gate),
      .band(band), .faults(faults));
   sense_model model_u (.clk(clk), .gate_drive_out(gate), .short_mode(shrt), .cs_limit_cmp(cs));
   // ---------
   // Tasks
   // ---------
   initial begin
      forever #4 clk = ~clk;
   end
   // Bound keeps a stuck gate from hanging the run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         fails++;
         tally_and_finish();
      end
   end
   task tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task rises(input int n, output int c);
      int k;
      logic p;
      k = 0;
      c = 0;
      p = gate;
      while (k < n && c < 2500 * n) begin
         @(negedge clk);
         c++;
         if (gate && !p) k++;
         p = gate;
      end
   endtask
   task wait_bit(input int b, input logic v, input int lim);
      for (int k = 0; k < lim && faults[b] !== v; k++) @(negedge clk);
   endtask
   task set_cond(input int sel, input logic v);
      case (sel)
         0: vdd = v;
         1: fov = v;
         2: fot = v;
         3: shrt = v;
         default: die = v;
      endcase
   endtask
   task t_band;
      for (int i = 0; i < 7; i++) begin
         fb = (i == 6) ? 5'h0f : 5'h10 >> i;
         repeat (6) @(negedge clk);
         `CHK("band", (i == 6) ? 3'h4 : 3'(5 - i), band)
      end
      $display("test band done");
   endtask
   task meas(input logic v, input logic b, input int f);
      int p;
      hv = v;
      fb = b ? 5'h10 : 5'h08;
      rises(3, t);
      rises(1, t);
      p = `CLK_KHZ / f;
      `CHK("period", 1'b1, t >= p * 95 / 100 && t <= p * 105 / 100 + 2)
   endtask
   task t_freq;
      meas(1'b0, 1'b0, `F_LOW_NORM_KHZ);
      meas(1'b0, 1'b1, `F_LOW_BOOST_KHZ);
      meas(1'b1, 1'b0, `F_HIGH_NORM_KHZ);
      meas(1'b1, 1'b1, `F_HIGH_BOOST_KHZ);
      $display("test freq done");
   endtask
   task t_pin;
      dis = 1'b1;
      repeat (6) @(negedge clk);
      `CHK("disabled", 1'b1, faults.disabled)
      `CHK("dis_gate", 1'b0, gate)
      dis = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("enabled", 1'b0, faults.disabled)
      brown = 1'b1;
      opp = 1'b1;
      repeat (2000) @(negedge clk);
      `CHK("brown_early", 1'b0, faults.brownout)
      `CHK("opp_early", 1'b0, faults.opp)
      brown = 1'b0;
      opp = 1'b0;
      $display("test pin done");
   endtask
   // Gap variant drops the cause once mid-count
   task qual(input int sel, input int n, input int b, input bit gap);
      rises(1, t);
      set_cond(sel, 1'b1);
      if (gap) begin
         rises(n - 1, t);
         set_cond(sel, 1'b0);
         rises(2, t);
         set_cond(sel, 1'b1);
      end
      rises(n - 1, t);
      repeat (10) @(negedge clk);
      `CHK("early", 1'b0, faults[b])
      wait_bit(b, 1'b1, 800);
      `CHK("trip", 1'b1, faults[b])
      repeat (4) @(negedge clk);
      `CHK("gate_off", 1'b0, gate)
      set_cond(sel, 1'b0);
      wait_bit(b, 1'b0, 2000);
      `CHK("release", 1'b0, faults[b])
      $display("test qual %0d done", sel);
   endtask
   initial begin
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      t_band();
      t_freq();
      t_pin();
      qual(0, `VDD_OV_CYCLES, 7, 1'b1);
      qual(1, `FLT_OV_CYCLES, 4, 1'b0);
      qual(2, `FLT_OT_CYCLES, 3, 1'b0);
      qual(3, `SHORT_CYCLES, 2, 1'b0);
      qual(4, `DIE_OT_CYCLES, 1, 1'b0);
      tally_and_finish();
   end
endmodule
